// file: rtl/port_e_cfg.svh
/*
  Offsets, field positions, codes and reset values of the port E
  function select block. Assumes nothing; definitions only.
*/
`ifndef PORT_E_CFG_SVH
`define PORT_E_CFG_SVH

// register indices; the byte address is four times the index
`define PE_DIR_IDX 32'hFFFF83B4
`define PE_FSH_IDX 32'hFFFF83B8
`define PE_FSL_IDX 32'hFFFF83BA

// reset values
`define PE_DIR_RST 16'h0000
`define PE_FSH_RST 16'h0000
`define PE_FSL_RST 16'h0000

// writable bits; the rest read as zero
`define PE_DIR_WMASK 16'hFFFF
`define PE_FSH_WMASK 16'hF000
`define PE_FSL_WMASK 16'h55FF

// field positions
`define PE_P15_POS 14
`define PE_P14_POS 12
`define PE_TMR_POS 8
`define PE_LOW_POS 0

// mode codes
`define PE_CODE_PORT 2'b00
`define PE_CODE_TIMER 2'b01
`define PE_CODE_DMA 2'b10
`define PE_CODE_HOLD 2'b11

`endif

// file: rtl/port_e_pkg.sv
/*
  Types of the port E function select block.
  Assumes the constants header is compiled alongside.
*/
package port_e_pkg;
  // what a pin is connected to
  typedef enum logic [3:0] {
    FN_PORT    = 4'h1,
    FN_TIMER   = 4'h2,
    FN_DMA_OUT = 4'h4,
    FN_DMA_IN  = 4'h8
  } pin_func_t;

  // register decoded from the bus address
  typedef enum logic [3:0] {
    SEL_NONE = 4'h1,
    SEL_DIR  = 4'h2,
    SEL_HIGH = 4'h4,
    SEL_LOW  = 4'h8
  } reg_sel_t;
endpackage

// file: rtl/port_e_sync.sv
/*
  Two-stage synchroniser for pin-level inputs.
  Assumes the inputs are asynchronous to mclk.
*/
`timescale 1ns/1ns
module port_e_sync #(
  parameter int WIDTH = 17
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Q;
  logic [WIDTH-1:0] stage2Q;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1Q <= '0;
      stage2Q <= '0;
    end else begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
    end
  end

  assign syncOut = stage2Q;
endmodule

// file: rtl/port_e_pin_drive.sv
/*
  Registered pin output and enable per port E pin.
  Assumes pin kinds and peripheral signals are on mclk.
*/
`timescale 1ns/1ns
module port_e_pin_drive (
  input wire logic mclk,
  input wire logic resetn,
  input port_e_pkg::pin_func_t pinKind [16],
  input wire logic [15:0] periphOut,
  input wire logic [15:0] periphOe,
  input wire logic [15:0] portDataOut,
  input wire logic [15:0] portDir,
  output logic [15:0] pinOut,
  output logic [15:0] pinOe
);
  logic [15:0] outD;
  logic [15:0] outQ;
  logic [15:0] oeD;
  logic [15:0] oeQ;

  // per-pin source select
  always_comb begin
    outD = '0;
    oeD = '0;
    for (int p = 0; p < 16; p++) begin
      case (pinKind[p])
        port_e_pkg::FN_PORT: begin
          outD[p] = portDataOut[p];
          oeD[p] = portDir[p];
        end
        port_e_pkg::FN_TIMER, port_e_pkg::FN_DMA_OUT: begin
          outD[p] = periphOut[p];
          oeD[p] = periphOe[p];
        end
        port_e_pkg::FN_DMA_IN: begin
          outD[p] = 1'b0;
          oeD[p] = 1'b0;
        end
        default: begin
          outD[p] = portDataOut[p];
          oeD[p] = portDir[p];
        end
      endcase
    end
  end

  // register the pads
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      outQ <= '0;
      oeQ <= '0;
    end else begin
      outQ <= outD;
      oeQ <= oeD;
    end
  end

  assign pinOut = outQ;
  assign pinOe = oeQ;
endmodule

// file: rtl/port_e_pin_function_select.sv
/*
  Port E pin function controller: direction register, two function
  select registers on APB, and routing of 16 pins to port, timer or
  DMA functions. Assumes APB master on mclk; pins and the single-chip
  strap are asynchronous; peripheral signals are on mclk.
*/
// Our own choice: the APB slave port.
// Summary of operation
// - a 16-bit direction register, one read/write bit per pin, resets to zero.
// - the high select register holds pin 15 at bits 15-14 and pin 14 at 13-12; 11-0 read zero.
// - pin 15 code 00 is port, code 10 the DMA channel 1 acknowledge; 01 and 11 reserved.
// - pin 14 code 00 is port, 10 the DMA channel 0 acknowledge, 11 address hold; 01 reserved.
// - in single-chip mode any DMA or address-hold selection leaves the pin a port pin.
// - the low select register has one-bit modes for pins 7-4 at bits 14,12,10,8, zeros at bits 15,13,11,9.
// - a one in the pin 7-4 mode connects timer 2 B, 2 A, 1 B, 1 A; a zero selects port.
// - code 01 on pins 3-0 connects timer 0 D, C, B, A; code 00 selects port.
// - pin 3 code 10 drives the DMA request 1 accepted status; 11 reserved.
// - pin 2 code 10 feeds the DMA channel 1 request input; 11 reserved.
// - pins 1 and 0 code 10 drive the DMA channel 0 request accepted status; 11 reserved.
// - every mode field resets to zero so all pins start as port pins.
// - the registers take 8, 16 and 32-bit accesses.
`timescale 1ns/1ns
`include "port_e_cfg.svh"
module port_e_pin_function_select (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic singleChipMode,
  input wire logic [15:0] pinIn,
  output logic [15:0] pinOut,
  output logic [15:0] pinOe,
  input wire logic [15:0] portDataOut,
  output logic [15:0] portDataIn,
  input wire logic [7:0] timerCapcompOut,
  input wire logic [7:0] timerCapcompOe,
  output logic [7:0] timerCapcompIn,
  input wire logic dma1Acknowledge,
  input wire logic dma0Acknowledge,
  input wire logic addressHoldOut,
  input wire logic dma1RequestAccepted,
  input wire logic dma0RequestAccepted,
  output logic dma1RequestIn
);
  logic [15:0] dirD, dirQ, fshD, fshQ, fslD, fslQ;
  logic [31:0] rdataD, rdataQ;
  logic errD, errQ;
  logic reqInD, reqInQ;
  logic [16:0] syncOut;
  logic singleChip;
  logic setupPhase, accessPhase;
  port_e_pkg::reg_sel_t busSel;
  logic [1:0] modeCode [16];
  port_e_pkg::pin_func_t pinKind [16];
  logic [15:0] periphOut, periphOe;

  // word address compare; byte address is four times the index
  function automatic port_e_pkg::reg_sel_t regSelect(input logic [31:0] addr);
    logic [31:0] dirIdx, fshIdx, fslIdx;
    dirIdx = `PE_DIR_IDX;
    fshIdx = `PE_FSH_IDX;
    fslIdx = `PE_FSL_IDX;
    if (addr[1:0] != 2'h0) return port_e_pkg::SEL_NONE;
    if (addr[31:2] == dirIdx[29:0]) return port_e_pkg::SEL_DIR;
    if (addr[31:2] == fshIdx[29:0]) return port_e_pkg::SEL_HIGH;
    if (addr[31:2] == fslIdx[29:0]) return port_e_pkg::SEL_LOW;
    return port_e_pkg::SEL_NONE;
  endfunction

  // byte-lane merge into a 16-bit register, read-only bits kept
  function automatic logic [15:0] mergeWrite(input logic [15:0] old,
      input logic [15:0] data, input logic [3:0] lanes, input logic [15:0] wmask);
    logic [15:0] m;
    m = {{8{lanes[1]}}, {8{lanes[0]}}} & wmask;
    return (old & ~m) | (data & m);
  endfunction

  // pin function from its mode code and the operating mode
  function automatic port_e_pkg::pin_func_t pinFunc(input int pin,
      input logic [1:0] code, input logic single);
    port_e_pkg::pin_func_t f;
    f = port_e_pkg::FN_PORT;
    case (pin)
      15: if (code == `PE_CODE_DMA) f = port_e_pkg::FN_DMA_OUT;
      14: if (code == `PE_CODE_DMA || code == `PE_CODE_HOLD) begin
        f = port_e_pkg::FN_DMA_OUT;
      end
      7, 6, 5, 4: if (code[0]) f = port_e_pkg::FN_TIMER;
      3, 1, 0: begin
        if (code == `PE_CODE_TIMER) f = port_e_pkg::FN_TIMER;
        if (code == `PE_CODE_DMA) f = port_e_pkg::FN_DMA_OUT;
      end
      2: begin
        if (code == `PE_CODE_TIMER) f = port_e_pkg::FN_TIMER;
        if (code == `PE_CODE_DMA) f = port_e_pkg::FN_DMA_IN;
      end
      default: f = port_e_pkg::FN_PORT;
    endcase
    // in single-chip mode DMA and address-hold functions fall back to port here
    if (single && (f == port_e_pkg::FN_DMA_OUT || f == port_e_pkg::FN_DMA_IN)) begin
      f = port_e_pkg::FN_PORT;
    end
    return f;
  endfunction

  // pins and the single-chip strap cross into mclk
  port_e_sync #(.WIDTH(17)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn({singleChipMode, pinIn}),
    .syncOut(syncOut)
  );

  assign singleChip = syncOut[16];
  assign portDataIn = syncOut[15:0];
  assign timerCapcompIn = syncOut[7:0];

  // bus phases; zero wait states
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign busSel = regSelect(paddr);
  assign pready = 1'b1;
  assign prdata = rdataQ;
  assign pslverr = errQ && accessPhase;

  // register writes at the access edge, read data staged at setup
  always_comb begin
    dirD = dirQ;
    fshD = fshQ;
    fslD = fslQ;
    rdataD = rdataQ;
    errD = errQ;
    if (accessPhase && pwrite) begin
      case (busSel)
        port_e_pkg::SEL_DIR: dirD = mergeWrite(dirQ, pwdata[15:0], pstrb,
          `PE_DIR_WMASK);
        port_e_pkg::SEL_HIGH: fshD = mergeWrite(fshQ, pwdata[15:0], pstrb,
          `PE_FSH_WMASK);
        port_e_pkg::SEL_LOW: fslD = mergeWrite(fslQ, pwdata[15:0], pstrb,
          `PE_FSL_WMASK);
        default: dirD = dirQ;
      endcase
    end
    if (setupPhase) begin
      errD = (busSel == port_e_pkg::SEL_NONE);
      rdataD = 32'h0000_0000;
      if (!pwrite) begin
        case (busSel)
          port_e_pkg::SEL_DIR: rdataD = {16'h0000, dirQ};
          port_e_pkg::SEL_HIGH: rdataD = {16'h0000, fshQ & `PE_FSH_WMASK};
          port_e_pkg::SEL_LOW: rdataD = {16'h0000, fslQ & `PE_FSL_WMASK};
          default: rdataD = 32'h0000_0000;
        endcase
      end
    end
  end

  // register file; all fields clear at reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dirQ <= `PE_DIR_RST;
      fshQ <= `PE_FSH_RST;
      fslQ <= `PE_FSL_RST;
      rdataQ <= 32'h0000_0000;
      errQ <= 1'b0;
    end else begin
      dirQ <= dirD;
      fshQ <= fshD;
      fslQ <= fslD;
      rdataQ <= rdataD;
      errQ <= errD;
    end
  end

  // mode code per pin, pins 13-8 have none
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      modeCode[p] = `PE_CODE_PORT;
    end
    modeCode[15] = fshQ[`PE_P15_POS +: 2];
    modeCode[14] = fshQ[`PE_P14_POS +: 2];
    for (int p = 0; p < 4; p++) begin
      modeCode[p] = fslQ[`PE_LOW_POS + 2 * p +: 2];
      modeCode[p + 4] = {1'b0, fslQ[`PE_TMR_POS + 2 * p]};
    end
  end

  // pin kind for every pin
  for (genvar g = 0; g < 16; g++) begin : g_kind
    assign pinKind[g] = pinFunc(g, modeCode[g], singleChip);
  end

  // peripheral output and enable for each pin
  always_comb begin
    periphOut = '0;
    periphOe = '0;
    periphOut[7:0] = timerCapcompOut;
    periphOe[7:0] = timerCapcompOe;
    periphOut[15] = dma1Acknowledge;
    periphOe[15] = 1'b1;
    periphOut[14] = (modeCode[14] == `PE_CODE_HOLD) ? addressHoldOut
      : dma0Acknowledge;
    periphOe[14] = 1'b1;
    if (pinKind[3] == port_e_pkg::FN_DMA_OUT) begin
      periphOut[3] = dma1RequestAccepted;
      periphOe[3] = 1'b1;
    end
    for (int p = 0; p < 2; p++) begin
      if (pinKind[p] == port_e_pkg::FN_DMA_OUT) begin
        periphOut[p] = dma0RequestAccepted;
        periphOe[p] = 1'b1;
      end
    end
  end

  // request input taken from pin 2 only when selected
  always_comb begin
    reqInD = (pinKind[2] == port_e_pkg::FN_DMA_IN) && syncOut[2];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reqInQ <= 1'b0;
    end else begin
      reqInQ <= reqInD;
    end
  end

  assign dma1RequestIn = reqInQ;

  // pad drivers
  port_e_pin_drive u_drive (
    .mclk(mclk),
    .resetn(resetn),
    .pinKind(pinKind),
    .periphOut(periphOut),
    .periphOe(periphOe),
    .portDataOut(portDataOut),
    .portDir(dirQ),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_dir_write: assert property (accessPhase && pwrite && busSel == port_e_pkg::SEL_DIR
    && pstrb[1:0] == 2'b11 |=> dirQ == $past(pwdata[15:0]))
    else $error("direction write not stored");
  a_byte_lane: assert property (accessPhase && pwrite && busSel == port_e_pkg::SEL_DIR
    && pstrb[1:0] == 2'b01 |=> dirQ[15:8] == $past(dirQ[15:8])
    && dirQ[7:0] == $past(pwdata[7:0]))
    else $error("byte write touched wrong lane");
  a_high_ro_zero: assert property (setupPhase && !pwrite
    && busSel == port_e_pkg::SEL_HIGH |=> prdata[31:16] == 16'h0000
    && prdata[11:0] == 12'h000 && prdata[15:12] == $past(fshQ[15:12]))
    else $error("high select read wrong");
  a_low_ro_zero: assert property (setupPhase && !pwrite
    && busSel == port_e_pkg::SEL_LOW |=> (prdata & 32'hFFFF_AA00) == 32'h0000_0000)
    else $error("low select reserved bits not zero");
  a_reset_fields: assert property ($rose(resetn) |-> fshQ == 16'h0000
    && fslQ == 16'h0000 && dirQ == 16'h0000)
    else $error("registers not cleared by reset");
  a_dma1_acknowledge_route: assert property (!singleChip && fshQ[15:14] == 2'b10
    |=> pinOut[15] == $past(dma1Acknowledge) && pinOe[15])
    else $error("pin 15 acknowledge route wrong");
  a_hold_route: assert property (!singleChip && fshQ[13:12] == 2'b11
    |=> pinOut[14] == $past(addressHoldOut) && pinOe[14])
    else $error("pin 14 address hold route wrong");
  a_single_chip: assert property (singleChip && fshQ[15:14] == 2'b10
    |=> pinOe[15] == $past(dirQ[15]) && pinOut[15] == $past(portDataOut[15]))
    else $error("single-chip pin 15 not a port pin");
  a_timer_route: assert property (fslQ[14]
    |=> pinOut[7] == $past(timerCapcompOut[7]) && pinOe[7] == $past(timerCapcompOe[7]))
    else $error("pin 7 timer route wrong");
  a_timer0_route: assert property (fslQ[1:0] == 2'b01
    |=> pinOut[0] == $past(timerCapcompOut[0]) && pinOe[0] == $past(timerCapcompOe[0]))
    else $error("pin 0 timer route wrong");
  a_dma1_request_accepted_route: assert property (!singleChip && fslQ[7:6] == 2'b10
    |=> pinOut[3] == $past(dma1RequestAccepted) && pinOe[3])
    else $error("pin 3 request accepted route wrong");
  a_dma1_request_in_route: assert property (!singleChip && fslQ[5:4] == 2'b10
    |=> dma1RequestIn == $past(syncOut[2]) && !pinOe[2])
    else $error("pin 2 request input route wrong");
  a_dma0_request_accepted_route: assert property (!singleChip && fslQ[3:2] == 2'b10
    |=> pinOut[1] == $past(dma0RequestAccepted) && pinOe[1])
    else $error("pin 1 request accepted route wrong");
  a_port_dir: assert property (fslQ[15:8] == 8'h00
    |=> pinOe[7:4] == $past(dirQ[7:4]) && pinOut[7:4] == $past(portDataOut[7:4]))
    else $error("port pin direction wrong");

  c_low_write: cover property (accessPhase && pwrite && busSel == port_e_pkg::SEL_LOW);
  c_bad_addr: cover property (pslverr);
  c_single_dma: cover property (singleChip && fshQ[13:12] == 2'b10);
  c_timer_on: cover property (fslQ[14] && timerCapcompOe[7]);
endmodule

// file: tb/test_port_e_pin_function_select.sv
/*
  Self-checking bench of the port E pin function controller: APB register
  access, strobes, unmapped addresses and pin routing under random settings.
  Assumes the design and its constants header are compiled first.
*/
`timescale 1ns/1ns
`include "port_e_cfg.svh"
module test_port_e_pin_function_select;
  // compare one value, count and report
  `define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; $display("Error at %0t: mismatch got %0h expected %0h", $time, got, exp); end end

  localparam logic [31:0] dirAddr = `PE_DIR_IDX << 2;
  localparam logic [31:0] highAddr = `PE_FSH_IDX << 2;
  localparam logic [31:0] lowAddr = `PE_FSL_IDX << 2;

  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic singleChipMode = 1'b0;
  logic [15:0] pinIn = 16'h0000, portDataOut = 16'h0000;
  logic [15:0] pinOut, pinOe, portDataIn;
  logic [7:0] timerCapcompOut = 8'h00, timerCapcompOe = 8'h00, timerCapcompIn;
  logic dma1Acknowledge = 1'b0, dma0Acknowledge = 1'b0, addressHoldOut = 1'b0;
  logic dma1RequestAccepted = 1'b0, dma0RequestAccepted = 1'b0, dma1RequestIn;
  int fails = 0, comparisons = 0;
  integer seed = 32'h96f4fba3;
  logic [31:0] rdat, r;
  logic rerr;
  logic [15:0] dirM = 16'h0000, highM = 16'h0000, lowM = 16'h0000, h, l;
  logic [1:0] c;

  port_e_pin_function_select port_e_pin_function_select_i (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .singleChipMode(singleChipMode), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .portDataOut(portDataOut), .portDataIn(portDataIn),
    .timerCapcompOut(timerCapcompOut), .timerCapcompOe(timerCapcompOe),
    .timerCapcompIn(timerCapcompIn), .dma1Acknowledge(dma1Acknowledge),
    .dma0Acknowledge(dma0Acknowledge), .addressHoldOut(addressHoldOut),
    .dma1RequestAccepted(dma1RequestAccepted), .dma0RequestAccepted(dma0RequestAccepted),
    .dma1RequestIn(dma1RequestIn)
  );

  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // byte-lane merge of a write into a register image
  function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d,
                                      input logic [3:0] s, input logic [15:0] m);
    logic [15:0] lane;
    lane = {{8{s[1]}}, {8{s[0]}}} & m;
    return (o & ~lane) | (d[15:0] & lane);
  endfunction

  // write and keep the bench image up to date
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
    if (a == dirAddr) dirM = mrg(dirM, d, s, 16'hFFFF);
    if (a == highAddr) highM = mrg(highM, d, s, 16'hF000);
    if (a == lowAddr) lowM = mrg(lowM, d, s, 16'h55FF);
  endtask

  // read back all three registers against the image
  task automatic readAll();
    apb(1'b0, dirAddr, 32'h0, 4'h0);
    `CHK(rdat, {16'h0000, dirM})
    apb(1'b0, highAddr, 32'h0, 4'h0);
    `CHK(rdat, {16'h0000, highM})
    apb(1'b0, lowAddr, 32'h0, 4'h0);
    `CHK(rdat, {16'h0000, lowM})
  endtask

  // expected {pinOut, pinOe} from the register images and live inputs
  function automatic logic [31:0] expPins();
    logic [15:0] o, e;
    logic [1:0] k;
    o = portDataOut;
    e = dirM;
    for (int i = 4; i < 8; i++) begin
      if (lowM[2*i]) begin
        o[i] = timerCapcompOut[i];
        e[i] = timerCapcompOe[i];
      end
    end
    for (int i = 0; i < 4; i++) begin
      k = lowM[2*i+1 -: 2];
      if (k == 2'b01) begin
        o[i] = timerCapcompOut[i];
        e[i] = timerCapcompOe[i];
      end else if (k == 2'b10 && !singleChipMode) begin
        o[i] = (i == 3) ? dma1RequestAccepted : (i == 2) ? 1'b0 : dma0RequestAccepted;
        e[i] = (i != 2);
      end
    end
    if (highM[15:14] == 2'b10 && !singleChipMode) begin
      o[15] = dma1Acknowledge;
      e[15] = 1'b1;
    end
    if (highM[13] && !singleChipMode) begin
      o[14] = highM[12] ? addressHoldOut : dma0Acknowledge;
      e[14] = 1'b1;
    end
    return {o, e};
  endfunction

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hung transfer
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    readAll(); // all zero after reset
    `CHK({pinOut, pinOe}, 32'h00000000)
    // unmapped and misaligned places answer with an error and read zero
    apb(1'b0, dirAddr + 32'h4, 32'h0, 4'h0);
    `CHK({rerr, rdat}, 33'h100000000)
    wr(dirAddr + 32'h2, 32'hFFFF, 4'hF);
    `CHK({rerr, rdat}, 33'h100000000)
    dirM = 16'h0000;
    // read-only bits and byte lanes
    for (int i = 0; i < 3; i++) begin
      wr(i == 0 ? dirAddr : i == 1 ? highAddr : lowAddr, 32'hFFFFFFFF, 4'hF);
    end
    wr(lowAddr, 32'h0, 4'h1);
    readAll();
    wr(lowAddr, 32'h0, 4'h2);
    wr(highAddr, 32'h0, 4'hF);
    readAll();
    for (int it = 0; it < 48; it++) begin
      r = $random(seed);
      if (it < 6) begin
        c = (it % 3 == 0) ? 2'b00 : (it % 3 == 1) ? 2'b10 : 2'b11;
        h = {(it % 2 == 1) ? 2'b10 : 2'b00, c, 12'h000};
        c = 2'(it % 3);
        l = {1'b0, it[0], 1'b0, it[0], 1'b0, it[0], 1'b0, it[0], c, c, c, c};
      end else begin
        h = {r[0], 1'b0, (r[2:1] == 2'b01) ? 2'b11 : r[2:1], 12'h000};
        l = r[31:16] & 16'h5500;
        for (int f = 0; f < 4; f++) begin
          l[2*f+1 -: 2] = (r[2*f+5 -: 2] == 2'b11) ? 2'b01 : r[2*f+5 -: 2];
        end
      end
      wr(highAddr, {16'h0000, h}, 4'hF);
      wr(lowAddr, {r[15:0], l}, it < 6 ? 4'h3 : {r[13:12], 2'b11});
      wr(dirAddr, $random(seed), 4'($random(seed)));
      readAll();
      @(posedge mclk);
      r = $random(seed);
      singleChipMode <= (it < 6) ? (it >= 3) : r[0];
      pinIn <= r[31:16];
      portDataOut <= r[15:0];
      r = $random(seed);
      timerCapcompOut <= r[7:0];
      timerCapcompOe <= r[15:8];
      {dma1Acknowledge, dma0Acknowledge, addressHoldOut} <= r[18:16];
      {dma1RequestAccepted, dma0RequestAccepted} <= r[20:19];
      repeat (5) @(posedge mclk);
      `CHK({pinOut, pinOe}, expPins())
      `CHK(portDataIn, pinIn)
      `CHK(timerCapcompIn, pinIn[7:0])
      `CHK(dma1RequestIn, lowM[5:4] == 2'b10 && !singleChipMode && pinIn[2])
    end
    final_report();
  end
endmodule
